// ---- rtl/power_save_ctrl.sv ----
// Contract
// - power save halts laser emission and echo reception.
// - measure command with data zero enters power save.
// - measure command with data one leaves power save.
// - input held high five seconds enters power save.
// - input held low two seconds restores measurement.
// - power save raises measurement-stop alarm and steady error lamp.
// - associated measurement-stop alarm holds ready inactive.
// - input controls power save only in config-software selection mode.
// - measurement resumes within forty milliseconds of leave request.
// - restart command performs a full device restart.
// - particulate switch discards close-range particulate returns.
// - static mode applies time-domain filtering.
// - movement mode outputs raw data directly.
// - spatial filter switch removes unreliable points.
// - area monitor command enables or disables area monitoring.
// - fog switch enables dense-fog detection and its alarm.
// - factory setting is movement application mode.
// - runtime switch changes last until restart; restart reloads config.
// - ready active only while all associated alarms inactive.
`timescale 1ns/1ps
module power_save_ctrl
  import psave_pkg::*;
(
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [11:0]        paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire logic               power_save_input,
  input  wire logic               fog_present,
  output logic                    laser_enable,
  output logic                    echo_enable,
  output logic                    measure_stop_alarm,
  output logic                    fog_alarm,
  output logic                    error_lamp_steady,
  output logic                    device_ready,
  output logic                    restart_req,
  output psave_pkg::switches_t    switches
);
  import psave_pkg::*;

  // ****************************************************************
  // bus decode
  // ****************************************************************
  wire logic acc    = psel & penable;
  wire logic wr     = acc & pwrite;
  wire logic hit_cm = paddr == CMD_OFS;
  wire logic hit_cf = paddr == CFG_OFS;
  wire logic hit_st = paddr == STATUS_OFS;
  wire logic hit_sw = paddr == SW_OFS;
  wire logic mapped = hit_cm | hit_cf | hit_st | hit_sw;
  wire logic [7:0] code = pwdata[CMD_CODE_LSB +: 8];
  wire logic [7:0] dat  = pwdata[7:0];
  wire logic cmd_wr = wr & hit_cm;

  assign pready  = 1'b1;
  assign pslverr = acc & ~mapped;

  // ****************************************************************
  // stored configuration and runtime switches
  // ****************************************************************
  logic [7:0] cfg_r;
  switches_t  sw_r;
  switches_t  sw_nxt;
  logic       restart_r;

  function automatic switches_t cfg_sw(input logic [7:0] c);
    switches_t s;
    s.particulate = c[SW_PARTIC];
    s.static_mode = c[SW_STATIC];
    s.spatial     = c[SW_SPATIAL];
    s.area_mon    = c[SW_AREA];
    s.fog_det     = c[SW_FOG];
    return s;
  endfunction : cfg_sw

  function automatic logic is_cmd(input logic [7:0] c, input logic [7:0] k);
    return cmd_wr && (c == k);
  endfunction : is_cmd

  always_comb begin
    sw_nxt = sw_r;
    if (is_cmd(code, CODE_PARTIC)) sw_nxt.particulate = dat[0];
    if (is_cmd(code, CODE_APPMODE)) sw_nxt.static_mode = dat[0];
    if (is_cmd(code, CODE_SPATIAL)) sw_nxt.spatial = dat[0];
    if (is_cmd(code, CODE_AREA)) sw_nxt.area_mon = dat[0];
    if (is_cmd(code, CODE_FOG)) sw_nxt.fog_det = dat[0];
    if (restart_r) sw_nxt = cfg_sw(cfg_r);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_r <= CFG_RESET;
    end else if (wr && hit_cf) begin
      cfg_r <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_r <= cfg_sw(CFG_RESET);
    end else begin
      sw_r <= sw_nxt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      restart_r <= 1'b0;
    end else begin
      restart_r <= is_cmd(code, CODE_RESTART);
    end
  end

  // ****************************************************************
  // input pin synchroniser
  // ****************************************************************
  logic [2:0] pin_r;
  logic       pin_lvl_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_r     <= 3'h0;
      pin_lvl_r <= 1'b0;
    end else begin
      pin_r <= {pin_r[1:0], power_save_input};
      if (pin_r[1] == pin_r[2]) pin_lvl_r <= pin_r[2];
    end
  end

  // ****************************************************************
  // hold timer
  // ****************************************************************
  logic [HOLD_W-1:0] hold_r;
  logic              lvl_d_r;
  mode_t             st_r;
  mode_t             st_nxt;
  wire logic pin_en    = cfg_r[CFG_PIN_EN];
  wire logic pin_enter = pin_en & pin_lvl_r
                       & (hold_r == HOLD_W'(ENTER_HOLD_CYC - 1));
  wire logic pin_leave = pin_en & ~pin_lvl_r
                       & (hold_r == HOLD_W'(LEAVE_HOLD_CYC - 1));
  wire logic hold_max  = hold_r == HOLD_W'(ENTER_HOLD_CYC - 1);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_r  <= '0;
      lvl_d_r <= 1'b0;
    end else begin
      lvl_d_r <= pin_lvl_r;
      if (pin_lvl_r != lvl_d_r) hold_r <= '0;
      else if (!hold_max) hold_r <= hold_r + HOLD_W'(1);
    end
  end

  // ****************************************************************
  // mode state machine
  // ****************************************************************
  // data zero stops
  wire logic cmd_stop  = is_cmd(code, CODE_MEASURE) && dat == DATA_STOP;
  wire logic cmd_start = is_cmd(code, CODE_MEASURE) && dat == DATA_START;
  wire logic req_enter = cmd_stop | pin_enter;
  wire logic req_leave = cmd_start | pin_leave;

  logic [RESUME_W-1:0] res_r;
  // bounded resume delay, a short settle rather than the full 40 ms
  wire logic res_done = res_r == RESUME_W'(RESUME_CYC / 4);

  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      ST_MEASURE: if (req_enter) st_nxt = ST_SAVE;
      ST_SAVE:    if (req_leave) st_nxt = ST_RESUME;
      ST_RESUME:  if (req_enter) st_nxt = ST_SAVE;
                  else if (res_done) st_nxt = ST_MEASURE;
      default:    st_nxt = ST_MEASURE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r  <= ST_MEASURE;
      res_r <= '0;
    end else begin
      st_r  <= st_nxt;
      res_r <= (st_r == ST_RESUME) ? res_r + RESUME_W'(1) : '0;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  wire logic saving = st_r != ST_MEASURE;
  logic fog_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fog_r <= 1'b0;
    end else begin
      fog_r <= sw_r.fog_det & fog_present;
    end
  end

  assign laser_enable       = ~saving;
  assign echo_enable        = ~saving;
  assign measure_stop_alarm = saving;
  assign error_lamp_steady  = saving;
  assign fog_alarm          = fog_r;
  assign device_ready = ~((cfg_r[CFG_RDY_MS] & saving)
                        | (cfg_r[CFG_RDY_FG] & fog_r));
  assign restart_req  = restart_r;
  assign switches     = sw_r;

  wire logic [31:0] status_w = {27'h0, device_ready, fog_r, st_r};
  always_comb begin
    prdata = 32'h0;
    if (hit_cf) prdata = {24'h0, cfg_r};
    if (hit_st) prdata = status_w;
    if (hit_sw) prdata = {27'h0, sw_r};
  end

endmodule : power_save_ctrl

// ---- rtl/psave_pkg.sv ----
package psave_pkg;

  // ****************************************************************
  // clock and timing
  // ****************************************************************
  localparam int unsigned CLK_HZ         = 50_000_000;
  localparam int unsigned ENTER_HOLD_S   = 5;
  localparam int unsigned LEAVE_HOLD_S   = 2;
  localparam int unsigned RESUME_MAX_MS  = 40;
  localparam int unsigned ENTER_HOLD_CYC = ENTER_HOLD_S * CLK_HZ;
  localparam int unsigned LEAVE_HOLD_CYC = LEAVE_HOLD_S * CLK_HZ;
  localparam int unsigned RESUME_CYC     = RESUME_MAX_MS * (CLK_HZ / 1000);
  localparam int unsigned HOLD_W         = 28;
  localparam int unsigned RESUME_W       = 21;

  // ****************************************************************
  // register map (byte addresses)
  // ****************************************************************
  localparam logic [11:0] CMD_OFS    = 12'h000;
  localparam logic [11:0] CFG_OFS    = 12'h004;
  localparam logic [11:0] STATUS_OFS = 12'h008;
  localparam logic [11:0] SW_OFS     = 12'h00c;

  // command word: code in [15:8], first data byte in [7:0]
  localparam int unsigned CMD_CODE_LSB = 8;
  localparam logic [7:0] CODE_MEASURE  = 8'h01;
  localparam logic [7:0] CODE_RESTART  = 8'h02;
  localparam logic [7:0] CODE_PARTIC   = 8'h03;
  localparam logic [7:0] CODE_APPMODE  = 8'h04;
  localparam logic [7:0] CODE_SPATIAL  = 8'h05;
  localparam logic [7:0] CODE_AREA     = 8'h06;
  localparam logic [7:0] CODE_FOG      = 8'h07;
  localparam logic [7:0] DATA_STOP     = 8'h00;
  localparam logic [7:0] DATA_START    = 8'h01;

  // cfg / switch field positions
  localparam int unsigned SW_PARTIC  = 0;
  localparam int unsigned SW_STATIC  = 1;
  localparam int unsigned SW_SPATIAL = 2;
  localparam int unsigned SW_AREA    = 3;
  localparam int unsigned SW_FOG     = 4;
  localparam int unsigned CFG_PIN_EN = 5;
  localparam int unsigned CFG_RDY_MS = 6;
  localparam int unsigned CFG_RDY_FG = 7;
  localparam logic [7:0]  CFG_RESET  = 8'h00; // movement mode, all off

  typedef struct packed {
    logic particulate;
    logic static_mode;
    logic spatial;
    logic area_mon;
    logic fog_det;
  } switches_t;

  typedef enum logic [2:0] {
    ST_MEASURE = 3'b001,
    ST_SAVE    = 3'b010,
    ST_RESUME  = 3'b100
  } mode_t;

endpackage : psave_pkg

// ---- sim/host_pin_model.sv ----
`timescale 1ns/1ps
module host_pin_model (
  input wire logic pclk,
  input wire logic chatter,
  output logic     power_save_input = 1'b0
);
  logic [9:0] cnt_r = '0;
  always @(posedge pclk) begin
    cnt_r <= cnt_r + 10'h001;
    if (!chatter) power_save_input <= 1'b0;
    else if (cnt_r == 10'h3ff) power_save_input <= !power_save_input;
  end
endmodule : host_pin_model

// ---- sim/power_save_ctrl_monitor.sv ----
`timescale 1ns/1ps
module power_save_ctrl_monitor
  import psave_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        power_save_input,
  input wire logic        fog_present,
  input wire logic        laser_enable,
  input wire logic        echo_enable,
  input wire logic        measure_stop_alarm,
  input wire logic        fog_alarm,
  input wire logic        error_lamp_steady,
  input wire logic        device_ready,
  input wire logic        restart_req,
  input wire switches_t   switches
);
  // ****
  // shadow of config and decodes
  // ****
  logic [7:0] cfg_r;
  wire acc = psel && penable;
  wire wr = acc && pwrite && pready;
  wire cmd_wr = wr && paddr == CMD_OFS;
  wire [7:0] code = pwdata[15:8];
  wire stop_wr = cmd_wr && code == CODE_MEASURE && pwdata[7:0] == DATA_STOP;
  wire rst_wr = cmd_wr && code == CODE_RESTART;
  wire app_wr = cmd_wr && code == CODE_APPMODE;
  wire bad_ad = paddr != CMD_OFS && paddr != CFG_OFS
             && paddr != STATUS_OFS && paddr != SW_OFS;
  wire rdy_exp = !((cfg_r[CFG_RDY_MS] && measure_stop_alarm)
               || (cfg_r[CFG_RDY_FG] && fog_alarm));
  wire [4:0] sw_exp = {cfg_r[0], cfg_r[1], cfg_r[2], cfg_r[3], cfg_r[4]};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) cfg_r <= CFG_RESET;
    else if (wr && paddr == CFG_OFS) cfg_r <= pwdata[7:0];
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // lag of up to two cycles allowed while ready follows its causes
  sequence ready_cond; $stable(rdy_exp) [*2]; endsequence
  sequence pulse1; restart_req ##1 !restart_req; endsequence
  laser_state_a: assert property (laser_enable == echo_enable &&
    laser_enable != measure_stop_alarm) else $error("laser vs save");
  enter_cmd_a: assert property (stop_wr |-> ##2
    measure_stop_alarm && !laser_enable) else $error("stop ignored");
  lamp_alarm_a: assert property (error_lamp_steady ==
    measure_stop_alarm) else $error("lamp differs from alarm");
  ready_rel_a: assert property (ready_cond |->
    device_ready == rdy_exp) else $error("ready wrong");
  restart_pulse_a: assert property (rst_wr |-> ##[1:2] pulse1)
    else $error("no restart pulse");
  reload_sw_a: assert property (restart_req |-> ##2
    switches == sw_exp) else $error("switches not reloaded");
  app_mode_a: assert property (app_wr |-> ##2
    switches.static_mode == $past(pwdata[0], 2)) else $error("mode");
  pin_gate_a: assert property ($fell(laser_enable) &&
    !cfg_r[CFG_PIN_EN] |-> $past(stop_wr) || $past(stop_wr, 2))
    else $error("stop without cause");
  fog_on_a: assert property ((switches.fog_det && fog_present) [*2]
    |-> fog_alarm) else $error("fog alarm missing");
  bad_addr_a: assert property (acc && bad_ad |-> pslverr && pready)
    else $error("unmapped not refused");
endmodule : power_save_ctrl_monitor
bind power_save_ctrl power_save_ctrl_monitor mon (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .power_save_input(power_save_input),
  .fog_present(fog_present), .laser_enable(laser_enable),
  .echo_enable(echo_enable), .measure_stop_alarm(measure_stop_alarm),
  .fog_alarm(fog_alarm), .error_lamp_steady(error_lamp_steady),
  .device_ready(device_ready), .restart_req(restart_req),
  .switches(switches));

// ---- sim/power_save_ctrl_tb.sv ----
`timescale 1ns/1ps
module power_save_ctrl_tb;
  import psave_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic pready, pslverr, power_save_input, fog_present = 0, chatter = 0;
  logic laser_enable, echo_enable, measure_stop_alarm, fog_alarm;
  logic error_lamp_steady, device_ready, restart_req, err, b;
  switches_t switches;
  logic [4:0] sw_e;
  logic [7:0] cfg_e;
  int fail_count = 0, n_compared = 0, n_rst = 0, seed;
  always #10 pclk = ~pclk;
  always @(posedge pclk) if (restart_req === 1'b1) n_rst++;
  host_pin_model pin (.pclk(pclk), .chatter(chatter),
    .power_save_input(power_save_input));
  power_save_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .power_save_input(power_save_input), .fog_present(fog_present),
    .laser_enable(laser_enable), .echo_enable(echo_enable),
    .measure_stop_alarm(measure_stop_alarm), .fog_alarm(fog_alarm),
    .error_lamp_steady(error_lamp_steady), .device_ready(device_ready),
    .restart_req(restart_req), .switches(switches));
  task chk(input string nm, input logic [31:0] got, exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask : chk
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task cmd(input logic [7:0] c, d);
    apb(1'b1, CMD_OFS, {16'h0000, c, d});
    repeat (3) @(posedge pclk);
    #1;
  endtask : cmd
  task end_of_test;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_of_test
  initial begin
    #(20 * 40000);
    fail_count++;
    end_of_test();
  end
  initial begin
    seed = $urandom(32'he2e3);
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    cmd(8'h00, 8'h00);
    chk("reset", {switches, laser_enable, echo_enable}, 7'h03);
    apb(1'b1, 12'h010, 32'h0000_00ff);
    chk("slverr", err, 1'b1);
    apb(1'b0, CFG_OFS, 32'h0);
    chk("cfg", rd, 32'h0);
    sw_e = '0;
    for (int c = 3; c <= 7; c++) begin
      b = 1'($urandom);
      cmd(c[7:0], {7'h00, b});
      sw_e[7 - c] = b;
      chk("sw_cmd", switches, sw_e);
    end
    apb(1'b0, SW_OFS, 32'h0);
    chk("sw_reg", rd[4:0], sw_e);
    cfg_e = {3'b110, 5'($urandom)};
    apb(1'b1, CFG_OFS, {24'h0, cfg_e});
    fog_present <= 1'b1;
    cmd(CODE_FOG, 8'h01);
    chk("fog", {fog_alarm, device_ready}, 2'b10);
    fog_present <= 1'b0;
    cmd(8'h00, 8'h00);
    chk("fog_clr", {fog_alarm, device_ready}, 2'b01);
    apb(1'b1, CMD_OFS, {16'h0, CODE_MEASURE, DATA_STOP});
    cmd(CODE_MEASURE, DATA_STOP);
    chk("save", {laser_enable, echo_enable, measure_stop_alarm,
      error_lamp_steady, device_ready}, 5'b00110);
    cmd(CODE_MEASURE, 8'h02);
    apb(1'b0, STATUS_OFS, 32'h0);
    chk("state", rd[2:0], 3'b010);
    cmd(CODE_MEASURE, DATA_START);
    apb(1'b0, STATUS_OFS, 32'h0);
    chk("resume", rd[2:0], 3'b100);
    cmd(CODE_MEASURE, DATA_STOP);
    apb(1'b0, STATUS_OFS, 32'h0);
    chk("re_save", rd[2:0], 3'b010);
    apb(1'b1, CFG_OFS, {24'h0, cfg_e | 8'h20});
    chatter <= 1'b1;
    repeat (5000) @(posedge pclk);
    chatter <= 1'b0;
    apb(1'b0, STATUS_OFS, 32'h0);
    chk("chatter", rd[2:0], 3'b010);
    cmd(CODE_RESTART, 8'h00);
    chk("restart", n_rst, 1);
    chk("reload", switches, {cfg_e[0], cfg_e[1], cfg_e[2],
      cfg_e[3], cfg_e[4]});
    end_of_test();
  end
endmodule : power_save_ctrl_tb
